// ===== include/flash_host_map.svh
// Command codes, unlock addresses and pin timing counts for the flash host controller.
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_READ_RESET 8'hF0
`define ADDR_WORD_UNLOCK1 12'h555
`define ADDR_WORD_UNLOCK2 12'h2AA
`define ADDR_BYTE_UNLOCK1 12'hAAA
`define ADDR_BYTE_UNLOCK2 12'h555
`define ACCESS_NS 70
`define CLK_PERIOD_NS 10
`define ACCESS_CYCLES ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS 40
`define STROBE_CYCLES ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOGGLE_BIT 6
`define POLL_BIT 7
`endif

// ===== include/flash_host_pkg.sv
// Types shared by the flash host controller.
package flash_host_pkg;
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_PROGRAM = 2'b01,
        OP_CHIP_ERASE = 2'b10,
        OP_SECTOR_ERASE = 2'b11
    } op_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CYCLE = 4'b0001,
        ST_NEXT = 4'b0010,
        ST_READ = 4'b0011,
        ST_POLL1 = 4'b0100,
        ST_POLL2 = 4'b0101,
        ST_DONE = 4'b0110
    } state_e;
endpackage

// ===== logic/flash_bus_cycle.sv
// One asynchronous bus cycle on the flash pins, write or read, paced in clock cycles.
`timescale 1ns/10ps
`include "flash_host_map.svh"
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int STROBE = `STROBE_CYCLES,
    parameter int ACCESS = `ACCESS_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic write_i,
    output logic we_n_o,
    output logic oe_n_o,
    output logic busy_o,
    output logic sample_o
);
    logic [7:0] cnt_reg;
    logic write_reg;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 8'h00;
            write_reg <= 1'b0;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            busy_o <= 1'b0;
            sample_o <= 1'b0;
        end else begin
            sample_o <= 1'b0;
            if (start_i && !busy_o) begin
                write_reg <= write_i;
                busy_o <= 1'b1;
                cnt_reg <= write_i ? 8'(STROBE) : 8'(ACCESS + 2);
                we_n_o <= !write_i;
                oe_n_o <= write_i;
            end else if (busy_o) begin
                if (cnt_reg == 8'h00) begin
                    // Strobe high again for a cycle gives the device its data latch edge.
                    busy_o <= 1'b0;
                    we_n_o <= 1'b1;
                    oe_n_o <= 1'b1;
                    sample_o <= !write_reg;
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
        end
    end
endmodule

// ===== logic/flash_host.sv
// Host controller that runs program and erase command sequences on a parallel flash.
`timescale 1ns/10ps
`include "flash_host_map.svh"
module flash_host
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire op_e op_i,
    input wire logic byte_mode_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic ack_o,
    output logic busy_o,
    output logic [15:0] rdata_o,
    output logic [ADDR_W-1:0] flash_addr_o,
    output logic [15:0] flash_dq_o,
    output logic [15:0] flash_dq_oe_o,
    input wire logic [15:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic flash_byte_n_o,
    input wire logic ready_busy_n_i
);
    state_e state_reg;
    op_e op_reg;
    logic byte_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic low_addr_reg;
    logic [15:0] data_reg;
    logic [2:0] step_reg;
    logic [2:0] steps;
    logic [15:0] dq_meta_reg;
    logic [15:0] dq_sync_reg;
    logic rb_meta_reg;
    logic rb_sync_reg;
    logic [7:0] poll_reg;
    logic start;
    logic cyc_write;
    logic cyc_we_n;
    logic cyc_oe_n;
    logic cyc_busy;
    logic cyc_sample;
    logic [11:0] cmd_addr;
    logic [7:0] cmd_data;

    // Unlock and command address for a cycle; byte mode uses the doubled pattern.
    function automatic logic [11:0] unlock_addr(input logic second, input logic bmode);
        if (second) begin
            unlock_addr = bmode ? `ADDR_BYTE_UNLOCK2 : `ADDR_WORD_UNLOCK2;
        end else begin
            unlock_addr = bmode ? `ADDR_BYTE_UNLOCK1 : `ADDR_WORD_UNLOCK1;
        end
    endfunction

    flash_bus_cycle u_cycle (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(start),
        .write_i(cyc_write),
        .we_n_o(cyc_we_n),
        .oe_n_o(cyc_oe_n),
        .busy_o(cyc_busy),
        .sample_o(cyc_sample)
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dq_meta_reg <= 16'h0000;
            dq_sync_reg <= 16'h0000;
            rb_meta_reg <= 1'b1;
            rb_sync_reg <= 1'b1;
        end else begin
            dq_meta_reg <= flash_dq_i;
            dq_sync_reg <= dq_meta_reg;
            rb_meta_reg <= ready_busy_n_i;
            rb_sync_reg <= rb_meta_reg;
        end
    end

    // Program needs four writes, erases six; a plain read needs none and runs one read cycle.
    always_comb begin
        case (op_reg)
            OP_PROGRAM: steps = 3'd3;
            OP_CHIP_ERASE: steps = 3'd5;
            OP_SECTOR_ERASE: steps = 3'd5;
            default: steps = 3'd0;
        endcase
    end

    always_comb begin
        cmd_addr = unlock_addr(1'b0, byte_reg);
        cmd_data = `CMD_UNLOCK1;
        case (step_reg)
            3'd0: begin
                cmd_addr = unlock_addr(1'b0, byte_reg);
                cmd_data = `CMD_UNLOCK1;
            end
            3'd1, 3'd4: begin
                cmd_addr = unlock_addr(1'b1, byte_reg);
                cmd_data = `CMD_UNLOCK2;
            end
            3'd2: begin
                cmd_addr = unlock_addr(1'b0, byte_reg);
                cmd_data = (op_reg == OP_PROGRAM) ? `CMD_PROGRAM : `CMD_ERASE_SETUP;
            end
            3'd3: begin
                cmd_addr = unlock_addr(1'b0, byte_reg);
                cmd_data = `CMD_UNLOCK1;
            end
            default: begin
                cmd_addr = unlock_addr(1'b0, byte_reg);
                cmd_data = (op_reg == OP_CHIP_ERASE) ? `CMD_CHIP_ERASE : `CMD_SECTOR_ERASE;
            end
        endcase
    end

    assign cyc_write = (state_reg == ST_CYCLE);
    // A sampling edge must not relaunch a read, or the strobe would stay low into idle.
    assign start = !cyc_busy && !cyc_sample && (state_reg == ST_CYCLE || state_reg == ST_READ
        || state_reg == ST_POLL1 || state_reg == ST_POLL2);

    // Last write of a program or sector erase sequence carries the target or sector address itself.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flash_addr_o <= '0;
            flash_dq_o <= 16'h0000;
            flash_dq_oe_o <= 16'h0000;
        end else if (start) begin
            if (cyc_write && step_reg == steps && op_reg != OP_CHIP_ERASE) begin
                flash_addr_o <= addr_reg;
                flash_dq_o <= (op_reg == OP_PROGRAM) ? data_reg
                    : {byte_reg ? low_addr_reg : 1'b0, 7'h00, `CMD_SECTOR_ERASE};
            end else if (cyc_write) begin
                flash_addr_o <= ADDR_W'(byte_reg ? cmd_addr[11:1] : cmd_addr[10:0]);
                flash_dq_o <= {byte_reg ? cmd_addr[0] : 1'b0, 7'h00, cmd_data};
            end else begin
                flash_addr_o <= addr_reg;
                flash_dq_o <= {low_addr_reg, 15'h0000};
            end
            // In byte mode the top data pin stays driven as the low address bit.
            flash_dq_oe_o <= cyc_write ? (byte_reg ? 16'h80FF : 16'hFFFF)
                : (byte_reg ? 16'h8000 : 16'h0000);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_byte_n_o <= 1'b1;
        end else begin
            flash_ce_n_o <= (state_reg == ST_IDLE || state_reg == ST_DONE);
            flash_oe_n_o <= cyc_oe_n;
            flash_we_n_o <= cyc_we_n;
            flash_byte_n_o <= !byte_reg;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            byte_reg <= 1'b0;
            addr_reg <= '0;
            low_addr_reg <= 1'b0;
            data_reg <= 16'h0000;
            step_reg <= 3'd0;
            poll_reg <= 8'h00;
            ack_o <= 1'b0;
            busy_o <= 1'b0;
            rdata_o <= 16'h0000;
        end else begin
            ack_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // Device powers up in array-read mode, so reads need no command.
                    if (req_i) begin
                        op_reg <= op_i;
                        byte_reg <= byte_mode_i;
                        addr_reg <= byte_mode_i ? addr_i : addr_i;
                        low_addr_reg <= wdata_i[15];
                        data_reg <= wdata_i;
                        step_reg <= 3'd0;
                        busy_o <= 1'b1;
                        state_reg <= (op_i == OP_READ) ? ST_READ : ST_CYCLE;
                    end
                end
                ST_CYCLE: if (!cyc_busy) state_reg <= ST_NEXT;
                ST_NEXT: begin
                    if (!cyc_busy) begin
                        if (step_reg == steps) begin
                            state_reg <= ST_POLL1;
                        end else begin
                            step_reg <= step_reg + 3'd1;
                            state_reg <= ST_CYCLE;
                        end
                    end
                end
                ST_READ: begin
                    if (cyc_sample) begin
                        rdata_o <= dq_sync_reg;
                        state_reg <= ST_DONE;
                    end
                end
                ST_POLL1: begin
                    if (cyc_sample) begin
                        poll_reg <= dq_sync_reg[7:0];
                        state_reg <= ST_POLL2;
                    end
                end
                ST_POLL2: begin
                    if (cyc_sample) begin
                        // Done when the toggle bit holds still and ready/busy is high.
                        if (poll_reg[`TOGGLE_BIT] == dq_sync_reg[`TOGGLE_BIT]
                            && rb_sync_reg) begin
                            rdata_o <= dq_sync_reg;
                            state_reg <= ST_DONE;
                        end else begin
                            poll_reg <= dq_sync_reg[7:0];
                        end
                    end
                end
                ST_DONE: begin
                    ack_o <= 1'b1;
                    busy_o <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== sim/flash_dev_model.sv
// Behavioural parallel flash that answers the host's bus cycles.
`timescale 1ns/10ps
`include "flash_host_map.svh"
module flash_dev_model #(
    parameter int OP_CYCLES = 50,
    parameter bit BOTTOM_BOOT = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic [18:0] addr_i,
    input wire logic [15:0] bus_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic byte_n_i,
    output logic [15:0] dq_o = 16'h0000,
    output logic ready_busy_n_o
);
    logic [15:0] mem [int];
    logic erased = 1'b0;
    logic tog = 1'b0;
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    int step = 0;
    int left = 0;
    logic [11:0] key;
    logic c1;
    logic c2;
    logic [7:0] d;
    logic [15:0] w;
    assign key = byte_n_i ? {1'b0, addr_i[10:0]} : {addr_i[10:0], bus_i[15]};
    assign c1 = key == (byte_n_i ? `ADDR_WORD_UNLOCK1 : `ADDR_BYTE_UNLOCK1);
    assign c2 = key == (byte_n_i ? `ADDR_WORD_UNLOCK2 : `ADDR_BYTE_UNLOCK2);
    assign d = bus_i[7:0];
    assign ready_busy_n_o = (left == 0);
    function automatic logic [15:0] word_at(input int a);
        if (mem.exists(a)) return mem[a];
        return erased ? 16'hFFFF : ~a[15:0];
    endfunction
    // Sector number of a word address; the small boot sectors sit at one end only.
    function automatic int sector_of(input int a);
        if (!BOTTOM_BOOT) begin
            if (a[18:15] != 4'hF) return a[18:15];
            if (!a[14]) return 15;
            if (!a[13]) return 16 + a[12];
            return 18;
        end
        if (a[18:15] != 4'h0) return a[18:15] + 3;
        if (a[14]) return 3;
        if (!a[13]) return 0;
        return 1 + a[12];
    endfunction
    always @(posedge clk_sys_i) begin
        we_q <= we_n_i;
        oe_q <= oe_n_i;
        w = word_at(int'(addr_i));
        if (left > 0) left <= left - 1;
        // Released lines flip every cycle so a late sample never looks valid.
        if (ce_n_i || oe_n_i) dq_o <= ~dq_o;
        else if (left > 0) dq_o <= {9'h000, tog, 6'h00};
        else if (!byte_n_i) dq_o <= {8'h00, bus_i[15] ? w[15:8] : w[7:0]};
        else dq_o <= w;
        if (!ce_n_i && !oe_n_i && oe_q && left > 0) tog <= ~tog;
        if (we_q && !we_n_i && !ce_n_i && left == 0) begin
            case (step)
                0, 4: step <= (c1 && d == `CMD_UNLOCK1) ? step + 1 : 0;
                1, 5: step <= (c2 && d == `CMD_UNLOCK2) ? step + 1 : 0;
                2: step <= !c1 ? 0 : d == `CMD_PROGRAM ? 3 : d == `CMD_ERASE_SETUP ? 4 : 0;
                3: begin
                    // Programming only clears bits, as in the real array.
                    if (!byte_n_i) mem[int'(addr_i)] = w & (bus_i[15] ? {d, 8'hFF} : {8'hFF, d});
                    else mem[int'(addr_i)] = w & bus_i;
                    left <= OP_CYCLES;
                    step <= 0;
                end
                6: begin
                    if (c1 && d == `CMD_CHIP_ERASE) begin
                        mem.delete();
                        erased <= 1'b1;
                        left <= OP_CYCLES * 2;
                    end else if (d == `CMD_SECTOR_ERASE) begin
                        foreach (mem[k]) if (sector_of(k) == sector_of(int'(addr_i))) mem[k] = 16'hFFFF;
                        left <= OP_CYCLES;
                    end
                    step <= 0;
                end
                default: step <= 0;
            endcase
        end
    end
endmodule

// ===== sim/flash_host_bench.sv
// Testbench for the flash host controller against a behavioural flash.
`timescale 1ns/10ps
module flash_host_bench
    import flash_host_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_i = 1'b0;
    op_e op_i = OP_READ;
    logic byte_mode_i = 1'b0;
    logic [18:0] addr_i = 19'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic ack_o, busy_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_byte_n_o;
    logic ready_busy_n_i, saw_busy;
    logic [18:0] flash_addr_o;
    logic [15:0] rdata_o, flash_dq_o, flash_dq_oe_o, flash_dq_i, dev_dq;
    int num_errors = 0;
    int samples_checked = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    assign flash_dq_i = (flash_dq_oe_o & flash_dq_o) | (~flash_dq_oe_o & dev_dq);
    flash_host u_dut (.clk_sys_i, .rst_i, .req_i, .op_i, .byte_mode_i, .addr_i, .wdata_i,
        .ack_o, .busy_o, .rdata_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_dq_i,
        .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_byte_n_o, .ready_busy_n_i);
    flash_dev_model u_dev (.clk_sys_i, .addr_i(flash_addr_o), .bus_i(flash_dq_i),
        .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
        .byte_n_i(flash_byte_n_o), .dq_o(dev_dq), .ready_busy_n_o(ready_busy_n_i));
    task automatic results();
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One request held for one clock cycle, then a bounded wait for the ack.
    task automatic do_op(input op_e o, input logic bm, input logic [18:0] a,
                         input logic [15:0] d);
        @(negedge clk_sys_i);
        op_i = o;
        byte_mode_i = bm;
        addr_i = a;
        wdata_i = d;
        req_i = 1'b1;
        @(negedge clk_sys_i);
        req_i = 1'b0;
        saw_busy = 1'b0;
        for (int i = 0; i < 5000 && ack_o !== 1'b1; i++) begin
            @(negedge clk_sys_i);
            if (ready_busy_n_i === 1'b0) saw_busy = 1'b1;
        end
        if (ack_o !== 1'b1) num_errors++;
    endtask
    task automatic t_boot_read();
        do_op(OP_READ, 1'b0, 19'h00055, 16'h0000);
        check(rdata_o, 16'hFFAA);
    endtask
    task automatic t_chip_erase();
        do_op(OP_CHIP_ERASE, 1'b0, 19'h00000, 16'h0000);
        check({15'h0, saw_busy}, 16'h0001);
        do_op(OP_READ, 1'b0, 19'h40200, 16'h0000);
        check(rdata_o, 16'hFFFF);
    endtask
    task automatic t_program();
        do_op(OP_PROGRAM, 1'b0, 19'h40200, 16'h1234);
        check({15'h0, saw_busy}, 16'h0001);
        do_op(OP_READ, 1'b0, 19'h40200, 16'h0000);
        check(rdata_o, 16'h1234);
        do_op(OP_PROGRAM, 1'b1, 19'h00100, 16'h803C);
        do_op(OP_READ, 1'b1, 19'h00100, 16'h8000);
        check({8'h00, rdata_o[7:0]}, 16'h003C);
        do_op(OP_READ, 1'b0, 19'h00100, 16'h0000);
        check(rdata_o, 16'h3CFF);
    endtask
    task automatic t_sector_erase();
        do_op(OP_SECTOR_ERASE, 1'b0, 19'h40000, 16'h0000);
        check({15'h0, saw_busy}, 16'h0001);
        do_op(OP_READ, 1'b0, 19'h40200, 16'h0000);
        check(rdata_o, 16'hFFFF);
        do_op(OP_READ, 1'b0, 19'h00100, 16'h0000);
        check(rdata_o, 16'h3CFF);
    endtask
    // Neighbouring small boot sectors: erasing one must leave the other intact.
    task automatic t_boot_sectors();
        do_op(OP_PROGRAM, 1'b0, 19'h7C010, 16'h5AA5);
        do_op(OP_PROGRAM, 1'b0, 19'h7D010, 16'h1234);
        do_op(OP_SECTOR_ERASE, 1'b0, 19'h7D000, 16'h0000);
        check({15'h0, saw_busy}, 16'h0001);
        do_op(OP_READ, 1'b0, 19'h7D010, 16'h0000);
        check(rdata_o, 16'hFFFF);
        do_op(OP_READ, 1'b0, 19'h7C010, 16'h0000);
        check(rdata_o, 16'h5AA5);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_boot_read();
        t_chip_erase();
        t_program();
        t_sector_erase();
        t_boot_sectors();
        results();
    end
    initial begin
        #400000;
        num_errors++;
        results();
    end
endmodule

// ===== sim/flash_host_sva.sv
// Port checker for the flash host controller.
`timescale 1ns/10ps
module flash_host_sva #(
    parameter int ADDR_W = 19
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic ack_o,
    input wire logic busy_o,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic [15:0] flash_dq_oe_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_we_n_o,
    input wire logic ready_busy_n_i
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    a_busy_ends: assert property (ack_o |-> !busy_o)
        else $error("busy after ack");
    a_req_taken: assert property (req_i && !busy_o && !ack_o |=> busy_o)
        else $error("request lost");
    a_ack_ready: assert property (ack_o |-> ready_busy_n_i)
        else $error("ack while device busy");
    a_read_quiet: assert property (!flash_oe_n_o |-> flash_dq_oe_o[14:0] == 15'h0)
        else $error("drive during read");
    a_one_strobe: assert property (!(!flash_oe_n_o && !flash_we_n_o))
        else $error("oe and we together");
    a_ce_strobe: assert property (!flash_oe_n_o || !flash_we_n_o |-> !flash_ce_n_o)
        else $error("strobe without select");
    a_we_width: assert property ($fell(flash_we_n_o)
        |-> !flash_we_n_o [*5] ##1 flash_we_n_o)
        else $error("write strobe width");
    a_write_hold: assert property (!flash_we_n_o && !$past(flash_we_n_o)
        |-> $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("write cycle moved");
endmodule

bind flash_host flash_host_sva #(.ADDR_W(ADDR_W)) u_sva (.clk_sys_i, .rst_i, .req_i, .ack_o,
    .busy_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o,
    .flash_we_n_o, .ready_busy_n_i);
